// ---- verilog/phy_rx_port.sv ----
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module phy_rx_port
   import phy_rx_port_pkg::*;
(
   input  wire logic        i_clk,           // 125 MHz core clock
   input  wire logic        i_rstn,          // Async reset, active low
   input  wire logic        i_psel,          // APB select
   input  wire logic        i_penable,       // APB enable
   input  wire logic        i_pwrite,        // APB direction
   input  wire logic [7:0]  i_paddr,         // APB byte address
   input  wire logic [31:0] i_pwdata,        // APB write data
   output logic      [31:0] o_prdata,        // APB read data
   output logic             o_pready,        // APB ready
   output logic             o_pslverr,       // APB error, unmapped address
   input  wire rx_path_t    i_rx,            // Receive path from decoder
   input  wire rx_pins_t    i_pins_in,       // Pin levels seen at pads
   output rx_pins_t         o_pins_out,      // Pin drive values
   output rx_pins_t         o_pins_oe,       // Pin output enables
   input  wire logic        i_irq_pin_in,    // Shared irq/tx error pin level
   output logic             o_irq_pin_out,   // Shared pin drive value
   output logic             o_irq_pin_oe,    // Shared pin enable, open drain
   output straps_t          o_straps,        // Captured straps
   output logic             o_tx_err_sub,    // Substitute error code group
   output logic             o_irq            // Interrupt, active high level
);

   function automatic logic [5:0] div_last(input logic speed100);
      div_last = speed100 ? DIV100 - 6'h1 : DIV10 - 6'h1;
   endfunction : div_last

   rx_pins_t    pins_s1_reg, pins_s2_reg;
   logic        txp_s1_reg, txp_s2_reg;
   port_state_t state_reg;
   logic [3:0]  settle_reg;
   straps_t     straps_reg;
   logic [2:0]  ctrl_reg;
   logic [EV_W-1:0] status_reg, mask_reg, ev;
   logic [5:0]  div_reg;
   logic        tick, rmii, speed100, suppress;
   logic [3:0]  rxd_reg;
   logic        rx_er_reg, rx_dv_reg, rx_clk_reg, col_reg, crs_reg;
   logic        oe_reg, rxclk_oe_reg;
   logic        crs_prev_reg, valid_prev_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg, pslverr_reg, irq_reg, tx_err_reg, irq_oe_reg;
   logic        apb_done, mapped;
   logic        run;

   // Pads are asynchronous to the core clock
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pins_s1_reg <= '0;
         pins_s2_reg <= '0;
         txp_s1_reg  <= 1'b0;
         txp_s2_reg  <= 1'b0;
      end else begin
         pins_s1_reg <= i_pins_in;
         pins_s2_reg <= pins_s1_reg;
         txp_s1_reg  <= i_irq_pin_in;
         txp_s2_reg  <= txp_s1_reg;
      end
   end

   // Settle long enough for the synchroniser to show the strapped levels
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg  <= ST_HOLD;
         settle_reg <= 4'h0;
      end else begin
         case (state_reg)
            ST_HOLD: begin
               settle_reg <= settle_reg + 4'h1;
               if (settle_reg == STRAP_SETTLE)
                  state_reg <= ST_RUN;
            end
            default: state_reg <= ST_RUN;
         endcase
      end
   end

   assign run = (state_reg == ST_RUN);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         straps_reg <= '0;
      end else if (state_reg == ST_HOLD && settle_reg == STRAP_SETTLE) begin
         straps_reg.mode                    <= pins_s2_reg.rxd[2:0];
         straps_reg.irq_pin_function_strap  <= pins_s2_reg.rxd[3];
         straps_reg.regulator_disable_strap <= pins_s2_reg.rx_clk;
         straps_reg.rmii_sel                <= pins_s2_reg.col;
         straps_reg.phy_addr_strap_bit4     <= pins_s2_reg.crs;
      end
   end

   assign rmii     = straps_reg.rmii_sel;
   assign speed100 = ctrl_reg[CTRL_SPEED100];

   // RX clock from the core clock; 125/5 = 25 MHz, 125/50 = 2.5 MHz
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_reg    <= 6'h0;
         rx_clk_reg <= 1'b0;
      end else begin
         if (tick || div_reg > div_last(speed100))
            div_reg <= 6'h0;
         else
            div_reg <= div_reg + 6'h1;
         rx_clk_reg <= run && (div_reg < (div_last(speed100) >> 1));
      end
   end

   // Data changes one core cycle before the receive clock rises, late in its low phase
   assign tick = (div_reg == div_last(speed100));

   // In RMII at 10M, loopback in half duplex and pre-delimiter preamble stay hidden
   assign suppress = rmii && !speed100 &&
                     (!i_rx.sfd_done ||
                      (ctrl_reg[CTRL_HALFDUP] && i_rx.loopback));

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rxd_reg   <= 4'h0;
         rx_er_reg <= 1'b0;
         rx_dv_reg <= 1'b0;
         col_reg   <= 1'b0;
         crs_reg   <= 1'b0;
      end else if (!run) begin
         rxd_reg   <= 4'h0;
         rx_er_reg <= 1'b0;
         rx_dv_reg <= 1'b0;
         col_reg   <= 1'b0;
         crs_reg   <= 1'b0;
      end else if (tick) begin
         crs_reg <= i_rx.crs;
         if (!rmii) begin
            rxd_reg   <= i_rx.valid ? i_rx.data : 4'h0;
            rx_dv_reg <= i_rx.valid;
            rx_er_reg <= ctrl_reg[CTRL_SYMBOL] ? i_rx.sym4 : i_rx.err;
            col_reg   <= i_rx.col;
         end else begin
            rxd_reg   <= {2'h0, (i_rx.valid && !suppress) ? i_rx.data[1:0] : 2'h0};
            rx_dv_reg <= 1'b0;
            // Driven for MACs that use it, harmless when left open
            rx_er_reg <= i_rx.err;
            col_reg   <= i_rx.crs && !(suppress && i_rx.sfd_done);
         end
      end
   end

   // Pins stay inputs until the straps have been caught
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         oe_reg       <= 1'b0;
         rxclk_oe_reg <= 1'b0;
      end else begin
         oe_reg       <= run;
         rxclk_oe_reg <= run && !rmii;
      end
   end

   assign o_pins_out = {rxd_reg, rx_er_reg, rx_dv_reg, rx_clk_reg, col_reg, crs_reg};
   assign o_pins_oe  = {{4{oe_reg}}, oe_reg, oe_reg, rxclk_oe_reg, oe_reg, oe_reg};
   assign o_straps   = straps_reg;

   // Shared pin: open-drain interrupt, or transmit error input
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_err_reg <= 1'b0;
         irq_oe_reg <= 1'b0;
      end else begin
         tx_err_reg <= run && !straps_reg.irq_pin_function_strap &&
                       speed100 && txp_s2_reg;
         irq_oe_reg <= run && straps_reg.irq_pin_function_strap &&
                       (|(status_reg & mask_reg));
      end
   end

   assign o_tx_err_sub  = tx_err_reg;
   assign o_irq_pin_out = 1'b0;
   assign o_irq_pin_oe  = irq_oe_reg;

   // Events
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         crs_prev_reg   <= 1'b0;
         valid_prev_reg <= 1'b0;
      end else begin
         crs_prev_reg   <= i_rx.crs;
         valid_prev_reg <= i_rx.valid;
      end
   end

   always_comb begin
      ev = '0;
      ev[EV_CARRIER] = run && i_rx.crs && !crs_prev_reg;
      ev[EV_COLL]    = run && i_rx.col;
      ev[EV_RXERR]   = run && i_rx.err && !ctrl_reg[CTRL_SYMBOL];
      ev[EV_FRAME]   = run && valid_prev_reg && !i_rx.valid;
   end

   // APB: one wait state so read data leaves from a flop
   assign apb_done = i_psel && i_penable && pready_reg;
   assign mapped   = (i_paddr == STATUS_OFS) || (i_paddr == MASK_OFS) ||
                     (i_paddr == CTRL_OFS) || (i_paddr == STRAP_OFS);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0;
      end else begin
         pready_reg  <= i_psel && i_penable && !pready_reg;
         pslverr_reg <= i_psel && i_penable && !pready_reg && !mapped;
         if (i_psel && i_penable && !pready_reg && !i_pwrite) begin
            if (i_paddr == STATUS_OFS)
               prdata_reg <= {28'h0, status_reg};
            else if (i_paddr == MASK_OFS)
               prdata_reg <= {28'h0, mask_reg};
            else if (i_paddr == CTRL_OFS)
               prdata_reg <= {29'h0, ctrl_reg};
            else if (i_paddr == STRAP_OFS)
               prdata_reg <= {25'h0, straps_reg};
            else
               prdata_reg <= 32'h0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_reg <= CTRL_RESET;
         mask_reg <= MASK_RESET;
      end else if (apb_done && i_pwrite) begin
         if (i_paddr == CTRL_OFS)
            ctrl_reg <= i_pwdata[2:0];
         else if (i_paddr == MASK_OFS)
            mask_reg <= i_pwdata[EV_W-1:0];
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         status_reg <= STATUS_RESET;
      end else if (apb_done && i_pwrite && i_paddr == STATUS_OFS) begin
         status_reg <= (status_reg & ~i_pwdata[EV_W-1:0]) | ev;
      end else begin
         status_reg <= status_reg | ev;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(status_reg & mask_reg);
   end

   assign o_prdata  = prdata_reg;
   assign o_pready  = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_irq     = irq_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_pins_input_hold: assert property (!run |=> o_pins_oe == '0)
      else $error("strap pins driven before capture");

   a_strap_capture: assert property ($rose(run) |-> o_straps ==
      {$past(pins_s2_reg.rxd[2:0]), $past(pins_s2_reg.rxd[3]), $past(pins_s2_reg.rx_clk),
       $past(pins_s2_reg.col), $past(pins_s2_reg.crs)})
      else $error("straps not taken from pins at release");

   a_mii_nibble: assert property (run && tick && !rmii |=>
      rxd_reg == ($past(i_rx.valid) ? $past(i_rx.data) : 4'h0))
      else $error("MII nibble mismatch");

   a_mii_valid: assert property (run && tick && !rmii |=> rx_dv_reg == $past(i_rx.valid))
      else $error("data valid does not track decoded data");

   a_rmii_upper: assert property (run && rmii |=> rxd_reg[3:2] == 2'h0)
      else $error("upper lines carry data in RMII");

   a_rxer_error: assert property (run && tick && !rmii && !ctrl_reg[CTRL_SYMBOL]
      |=> rx_er_reg == $past(i_rx.err))
      else $error("receive error not reported");

   a_rxer_symbol: assert property (run && tick && !rmii && ctrl_reg[CTRL_SYMBOL]
      |=> rx_er_reg == $past(i_rx.sym4))
      else $error("symbol bit 4 not on error pin");

   a_mii_collision: assert property (run && tick && !rmii |=> col_reg == $past(i_rx.col))
      else $error("collision not presented");

   a_rmii_sfd_hold: assert property (run && tick && rmii && !speed100 && !i_rx.sfd_done
      |=> rxd_reg == 4'h0 ##0 col_reg == $past(i_rx.crs))
      else $error("data before delimiter or carrier/valid dropped");

   a_no_loopback: assert property (run && tick && rmii && !speed100 &&
      ctrl_reg[CTRL_HALFDUP] && i_rx.loopback |=> rxd_reg == 4'h0)
      else $error("transmit data looped back");

   a_txer_ignored_10: assert property (!speed100 |=> !o_tx_err_sub)
      else $error("transmit error honoured at 10M");

   a_rxclk_period: assert property (($rose(rx_clk_reg) && speed100) ##1 speed100 [*4]
      |=> $rose(rx_clk_reg))
      else $error("receive clock not 25MHz");

   c_strap_rmii: cover property ($rose(run) ##1 rmii);
   c_mii_frame: cover property (run && !rmii ##1 $rose(rx_dv_reg) ##[1:100] $fell(rx_dv_reg));
   c_irq_raise: cover property ($rose(o_irq));

endmodule : phy_rx_port
`default_nettype wire

// ---- verilog/phy_rx_port_pkg.sv ----
// Overview of operation
// - Received data leaves as a 4-bit nibble, each line one fixed bit.
// - Receive data lines 0..2 strap the 3-bit default operating mode.
// - In RMII only data lines 0 and 1 carry data; 2 and 3 unused.
// - Line 3 strap at reset: high picks interrupt output, low picks transmit error.
// - Receive error is raised when an error is seen in the current frame.
// - In MII symbol mode the error pin carries code-group bit 4 instead.
// - In RMII the receive error signal is optional for both ends.
// - In MII data valid is high exactly while decoded nibbles are presented.
// - MII receive clock is 25MHz at 100Mbit/s and 2.5MHz at 10Mbit/s.
// - Receive clock pin strap high disables the internal 1.8V regulator.
// - In MII the collision pin follows the detected collision condition.
// - Collision pin strap, latched at reset release, selects MII or RMII.
// - In RMII the combined carrier/valid output is high while medium non-idle.
// - RMII at 10Mbit/s holds data lines low until the frame delimiter.
// - RMII 10Mbit/s half duplex never loops transmit data onto receive lines.
// - Carrier sense pin follows carrier; it also straps address bit 4.
// - Transmit error input substitutes error code at 100Mbit/s, ignored at 10.
package phy_rx_port_pkg;

   localparam logic [7:0]  STATUS_OFS = 8'h00;
   localparam logic [7:0]  MASK_OFS   = 8'h04;
   localparam logic [7:0]  CTRL_OFS   = 8'h08;
   localparam logic [7:0]  STRAP_OFS  = 8'h0C;

   localparam int          EV_CARRIER = 0;
   localparam int          EV_COLL    = 1;
   localparam int          EV_RXERR   = 2;
   localparam int          EV_FRAME   = 3;
   localparam int          EV_W       = 4;

   localparam int          CTRL_SPEED100 = 0;
   localparam int          CTRL_SYMBOL   = 1;
   localparam int          CTRL_HALFDUP  = 2;
   localparam logic [2:0]  CTRL_RESET    = 3'h1;
   localparam logic [EV_W-1:0] STATUS_RESET = 4'h0;
   localparam logic [EV_W-1:0] MASK_RESET   = 4'h0;

   localparam longint      CLK_HZ       = 125_000_000;
   localparam longint      RXCLK100_HZ  = 25_000_000;
   localparam longint      RXCLK10_HZ   = 2_500_000;
   localparam logic [5:0]  DIV100       = 6'(CLK_HZ / RXCLK100_HZ);
   localparam logic [5:0]  DIV10        = 6'(CLK_HZ / RXCLK10_HZ);

   localparam logic [3:0]  STRAP_SETTLE = 4'h4;

   typedef struct packed {
      logic [3:0] rxd;
      logic       rx_er;
      logic       rx_dv;
      logic       rx_clk;
      logic       col;
      logic       crs;
   } rx_pins_t;

   typedef struct packed {
      logic       valid;
      logic [3:0] data;
      logic       sym4;
      logic       err;
      logic       col;
      logic       crs;
      logic       sfd_done;
      logic       loopback;
   } rx_path_t;

   typedef struct packed {
      logic [2:0] mode;
      logic       irq_pin_function_strap;
      logic       regulator_disable_strap;
      logic       rmii_sel;
      logic       phy_addr_strap_bit4;
   } straps_t;

   typedef enum logic [1:0] {ST_HOLD, ST_RUN} port_state_t;

endpackage : phy_rx_port_pkg

// ---- sim/mac_rx_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mac_rx_model
   import phy_rx_port_pkg::*;
(
   input  wire logic     i_clk,    // Core clock
   input  wire rx_pins_t i_out,    // Device pin drive values
   input  wire rx_pins_t i_oe,     // Device pin enables
   input  wire rx_pins_t i_pull,   // Strap resistor level on each pad
   output rx_pins_t      o_pads,   // Resolved pad levels
   output logic [3:0]    o_nib,    // Nibble taken at receive clock rise
   output logic          o_dv,     // Data valid taken at receive clock rise
   output int            o_period  // Core cycles between receive clock rises
);
   logic prev_clk = 1'b0;
   int   cnt      = 0;

   // Controller never drives the pads; released pads fall back to their resistor,
   // which keeps error and valid low through reset
   assign o_pads = (i_oe & i_out) | (~i_oe & i_pull);

   // Edges found by oversampling with the core clock, as a real controller's logic would
   always_ff @(posedge i_clk) begin
      prev_clk <= o_pads.rx_clk;
      cnt      <= cnt + 1;
      if (o_pads.rx_clk && !prev_clk) begin
         o_nib    <= o_pads.rxd;
         o_dv     <= o_pads.rx_dv;
         o_period <= cnt + 1;
         cnt      <= 0;
      end
   end
endmodule : mac_rx_model
`default_nettype wire

// ---- sim/phy_rx_port_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module phy_rx_port_tb_top;
   import phy_rx_port_pkg::*;

   logic        i_clk   = 1'b0;
   logic        i_rstn  = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   rx_path_t    rx      = '0;
   rx_pins_t    pull    = '0;
   rx_pins_t    pads;
   rx_pins_t    pout;
   rx_pins_t    poe;
   rx_pins_t    s1;
   rx_pins_t    s2;
   logic        irq_out;
   logic        irq_oe;
   logic        irq_pad;
   logic        txer_mode = 1'b0;
   logic        tx_er     = 1'b0;
   logic        irq;
   logic        txsub;
   straps_t     straps;
   logic [3:0]  nib;
   logic        dv;
   int          period;
   logic [31:0] rd;
   logic        er;
   int          failures   = 0;
   int          n_compared = 0;

   // Shared pin is open drain with a pull-up; the controller drives it only as transmit error
   assign irq_pad = irq_oe ? irq_out : (txer_mode ? tx_er : 1'b1);

   always #4 i_clk = ~i_clk;

   phy_rx_port dut (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_rx(rx), .i_pins_in(pads),
      .o_pins_out(pout), .o_pins_oe(poe), .i_irq_pin_in(irq_pad),
      .o_irq_pin_out(irq_out), .o_irq_pin_oe(irq_oe), .o_straps(straps),
      .o_tx_err_sub(txsub), .o_irq(irq));

   mac_rx_model mac (
      .i_clk(i_clk), .i_out(pout), .i_oe(poe), .i_pull(pull), .o_pads(pads),
      .o_nib(nib), .o_dv(dv), .o_period(period));

   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      // The slave sets the pace; only the watchdog ends a hung wait
      do begin
         @(posedge i_clk);
      end while (pready !== 1'b1);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Decoder fields: valid, data, sym4, err, col, crs, sfd_done, loopback
   task automatic drive(input logic [10:0] v, input int n);
      @(posedge i_clk);
      rx <= v;
      repeat (n) @(posedge i_clk);
   endtask : drive

   task automatic do_reset(input rx_pins_t p);
      @(posedge i_clk);
      i_rstn <= 1'b0;
      pull   <= p;
      rx     <= '0;
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (2) @(posedge i_clk);
      chk("oe in hold", 32'h0, 32'(poe));
      repeat (10) @(posedge i_clk);
   endtask : do_reset

   initial begin
      repeat (20000) @(posedge i_clk);
      failures++;
      wrap_up();
   end

   initial begin
      s1 = '0;
      s1.rxd = 4'hD;
      s1.rx_clk = 1'b1;
      s1.crs = 1'b1;
      s2 = '0;
      s2.rxd = 4'h2;
      s2.col = 1'b1;
      do_reset(s1);
      chk("straps", 32'h5D, 32'(straps));
      apb(1'b1, STRAP_OFS, 32'h0);
      apb(1'b0, STRAP_OFS, 32'h0);
      chk("strap reg", 32'h5D, rd);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'(CTRL_RESET), rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rd);
      $display("test straps and registers done");

      drive({1'b1, 4'hA, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0}, 20);
      chk("rxd", 32'hA, 32'(pout.rxd));
      chk("rx_dv", 32'h1, 32'(pout.rx_dv));
      chk("rx_er", 32'h1, 32'(pout.rx_er));
      chk("col", 32'h1, 32'(pout.col));
      chk("crs", 32'h1, 32'(pout.crs));
      chk("oe mii", 32'h1FF, 32'(poe));
      chk("mac nibble", 32'hA, 32'(nib));
      chk("mac dv", 32'h1, 32'(dv));
      chk("period 100", 32'h5, 32'(period));
      drive({1'b1, 4'h5, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0}, 20);
      chk("rxd 2", 32'h5, 32'(nib));
      chk("rx_er 0", 32'h0, 32'(pout.rx_er));
      chk("col 0", 32'h0, 32'(pout.col));
      apb(1'b1, CTRL_OFS, 32'h3);
      drive({1'b1, 4'h3, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0}, 20);
      chk("sym bit4 1", 32'h1, 32'(pout.rx_er));
      drive({1'b1, 4'h3, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0}, 20);
      chk("sym bit4 0", 32'h0, 32'(pout.rx_er));
      apb(1'b1, CTRL_OFS, 32'h0);
      drive({1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0}, 150);
      chk("period 10", 32'd50, 32'(period));
      chk("rx_dv idle", 32'h0, 32'(pout.rx_dv));
      $display("test mii receive done");

      apb(1'b1, CTRL_OFS, 32'h1);
      apb(1'b1, STATUS_OFS, 32'hF);
      drive({1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0}, 20);
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("carrier event", 32'h1, 32'(rd[EV_CARRIER]));
      apb(1'b1, MASK_OFS, 32'h1);
      repeat (3) @(posedge i_clk);
      chk("irq set", 32'h1, 32'(irq));
      chk("irq pin", 32'h1, 32'(irq_oe));
      chk("irq pin level", 32'h0, 32'(irq_pad));
      apb(1'b1, STATUS_OFS, 32'h1);
      repeat (3) @(posedge i_clk);
      chk("irq clear", 32'h0, 32'(irq));
      chk("irq pin off", 32'h0, 32'(irq_oe));
      $display("test interrupt done");

      do_reset(s2);
      chk("straps 2", 32'h22, 32'(straps));
      txer_mode <= 1'b1;
      tx_er     <= 1'b1;
      repeat (6) @(posedge i_clk);
      chk("tx err 100", 32'h1, 32'(txsub));
      tx_er     <= 1'b0;
      repeat (6) @(posedge i_clk);
      chk("tx err idle", 32'h0, 32'(txsub));
      drive({1'b1, 4'hF, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0}, 20);
      chk("crs_dv", 32'h1, 32'(pout.col));
      chk("rmii rxd", 32'h3, 32'(pout.rxd));
      chk("rmii no clk", 32'h0, 32'(poe.rx_clk));
      apb(1'b1, CTRL_OFS, 32'h4);
      drive({1'b1, 4'hF, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0}, 150);
      chk("pre delimiter", 32'h0, 32'(pout.rxd));
      chk("crs_dv 10", 32'h1, 32'(pout.col));
      tx_er <= 1'b1;
      drive({1'b1, 4'hF, 1'b0, 1'b0, 1'b0, 1'b1, 2'h2}, 150);
      chk("post delimiter", 32'h3, 32'(pout.rxd));
      chk("tx err 10", 32'h0, 32'(txsub));
      drive({1'b1, 4'hF, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3}, 150);
      chk("no loopback", 32'h0, 32'(pout.rxd));
      $display("test rmii receive done");
      wrap_up();
   end
endmodule : phy_rx_port_tb_top
`default_nettype wire
